// ### core/opb_pkg.sv
// Constants, field layout and types of the burn buffer and status block
// Overview of operation
// - Mode-ready flag (status bit 2) drops whenever the mode selection changes.
// - Mode-ready flag returns to 1 once the new mode is usable.
// - Buffer-empty flag (status bit 1) is 0 while a request is pending.
// - Buffer-empty flag clears when an address write starts a burn in burn mode.
// - Address and data registers ignore writes while the buffer is occupied.
// - Burn-idle flag (status bit 0) is 0 during a burn, 1 when idle.
// - Address register holds a 12-bit word address; above 3071 is invalid.
// - An address write starts a burn only while burn mode is active.
// - Address and data form a single-entry buffer holding one burn request.
// - Mode code 0x3 is burn; 0x0,0x1,0x2,0x4,0x5,0x6 are the others.
package opb_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS      = 25;
    localparam int unsigned MODE_SETTLE_NS     = 1000;
    localparam int unsigned MODE_SETTLE_CYCLES =
        (MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CNT_W       = 8;

    // Register byte addresses
    localparam logic [31:0] OFS_STATUS      = 32'h07f4_0004;
    localparam logic [31:0] OFS_BURN_ADDR   = 32'h07f4_0008;
    localparam logic [31:0] OFS_BURN_DATA   = 32'h07f4_000c;
    localparam logic [31:0] OFS_IRQ_STATUS  = 32'h07f4_0020;
    localparam logic [31:0] OFS_IRQ_CLEAR   = 32'h07f4_0024;
    localparam logic [31:0] OFS_IRQ_ENABLE  = 32'h07f4_0028;

    // Status fields
    localparam int unsigned STAT_IDLE_BIT   = 0;
    localparam int unsigned STAT_EMPTY_BIT  = 1;
    localparam int unsigned STAT_MRDY_BIT   = 2;
    localparam logic        STAT_IDLE_RST   = 1'b1;
    localparam logic        STAT_EMPTY_RST  = 1'b1;
    localparam logic        STAT_MRDY_RST   = 1'b1;

    // Burn address field
    localparam int unsigned BURN_ADDR_W     = 12;
    localparam logic [11:0] BURN_ADDR_MAX   = 12'h0bff;
    localparam logic [11:0] BURN_ADDR_RST   = 12'h000;
    localparam logic [31:0] BURN_DATA_RST   = 32'h0000_0000;

    // Mode codes
    localparam int unsigned MODE_W          = 3;
    localparam logic [2:0]  MODE_DSTBY      = 3'h0;
    localparam logic [2:0]  MODE_STBY       = 3'h1;
    localparam logic [2:0]  MODE_READ       = 3'h2;
    localparam logic [2:0]  MODE_BURN       = 3'h3;
    localparam logic [2:0]  MODE_VERIFY     = 3'h4;
    localparam logic [2:0]  MODE_INIT_READ  = 3'h5;
    localparam logic [2:0]  MODE_COPY       = 3'h6;

    // Interrupt event bits
    localparam int unsigned IRQ_W           = 4;
    localparam int unsigned IRQ_BURN_DONE   = 0;
    localparam int unsigned IRQ_MODE_READY  = 1;
    localparam int unsigned IRQ_ADDR_ERR    = 2;
    localparam int unsigned IRQ_BUF_FREE    = 3;
    localparam logic [3:0]  IRQ_RST         = 4'h0;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        OPB_ST_IDLE,
        OPB_ST_REQ,
        OPB_ST_BURN,
        OPB_ST_CLOSE
    } opb_burn_state_t;

endpackage

// ### core/opb_sync2.sv
// Two-flop synchroniser for levels from the array macro
`timescale 1ns/10ps
module opb_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_chk
        $error("opb_sync2 needs WIDTH of at least 1");
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// ### core/opb_top.sv
// Burn request buffer, status flags and interrupt logic with AXI4-Lite slave
`timescale 1ns/10ps
module opb_top #(
    parameter int unsigned SETTLE_CYCLES = opb_pkg::MODE_SETTLE_CYCLES,
    parameter int unsigned ADDR_MAX      = 3071
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // AXI4-Lite write address
    input  wire logic [31:0] axi_awaddr_in,
    input  wire logic [2:0]  axi_awprot_in,
    input  wire logic        axi_awvalid_in,
    output logic             axi_awready_out,
    // AXI4-Lite write data
    input  wire logic [31:0] axi_wdata_in,
    input  wire logic [3:0]  axi_wstrb_in,
    input  wire logic        axi_wvalid_in,
    output logic             axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0]       axi_bresp_out,
    output logic             axi_bvalid_out,
    input  wire logic        axi_bready_in,
    // AXI4-Lite read address
    input  wire logic [31:0] axi_araddr_in,
    input  wire logic [2:0]  axi_arprot_in,
    input  wire logic        axi_arvalid_in,
    output logic             axi_arready_out,
    // AXI4-Lite read data
    output logic [31:0]      axi_rdata_out,
    output logic [1:0]       axi_rresp_out,
    output logic             axi_rvalid_out,
    input  wire logic        axi_rready_in,
    // Mode selection from the mode register
    input  wire logic [2:0]  op_mode_select_in,
    output logic             mode_ready_flag_out,
    // Array burn port
    output logic             arr_burn_req_out,
    output logic [11:0]      arr_burn_word_address_out,
    output logic [31:0]      arr_burn_word_value_out,
    input  wire logic        arr_burn_ack_in,
    input  wire logic        arr_burn_done_in,
    // Interrupt
    output logic             irq_out
);

    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << opb_pkg::SETTLE_CNT_W)) begin : g_chk_s
        $error("SETTLE_CYCLES out of counter range");
    end
    if (ADDR_MAX >= (1 << opb_pkg::BURN_ADDR_W)) begin : g_chk_a
        $error("ADDR_MAX does not fit the address field");
    end

    localparam logic [7:0]  SETTLE_LAST = 8'(SETTLE_CYCLES - 1);
    localparam logic [11:0] ADDR_LIMIT  = 12'(ADDR_MAX);

    function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] ofs);
        reg_hit = (addr[31:2] == ofs[31:2]);
    endfunction

    function automatic logic known_reg(input logic [31:0] addr);
        known_reg = reg_hit(addr, opb_pkg::OFS_STATUS) ||
                    reg_hit(addr, opb_pkg::OFS_BURN_ADDR) ||
                    reg_hit(addr, opb_pkg::OFS_BURN_DATA) ||
                    reg_hit(addr, opb_pkg::OFS_IRQ_STATUS) ||
                    reg_hit(addr, opb_pkg::OFS_IRQ_CLEAR) ||
                    reg_hit(addr, opb_pkg::OFS_IRQ_ENABLE);
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        merge_strb = res;
    endfunction

    // Write channel holding registers
    logic [31:0]                aw_addr;
    logic                       aw_held;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       w_held;
    logic                       wr_fire;

    // Register state
    logic [11:0]                burn_word_address;
    logic [31:0]                burn_word_value;
    logic                       buf_full;
    logic                       mode_ready_flag;
    logic [2:0]                 prev_mode;
    logic [7:0]                 settle_cnt;
    logic [opb_pkg::IRQ_W-1:0]  irq_status;
    logic [opb_pkg::IRQ_W-1:0]  irq_enable;
    logic [opb_pkg::IRQ_W-1:0]  irq_events;
    logic [opb_pkg::IRQ_W-1:0]  irq_clear;
    opb_pkg::opb_burn_state_t   state;

    // Decoded strobes
    logic                       mode_changed;
    logic                       burn_mode_active;
    logic                       wr_addr_reg;
    logic                       wr_data_reg;
    logic                       addr_valid;
    logic                       burn_start;
    logic                       addr_err;
    logic                       burn_taken;
    logic                       burn_finished;
    logic                       mode_done;
    logic                       burn_idle_flag;
    logic [31:0]                status_word;
    logic [31:0]                next_addr_word;

    // Synchronised array levels
    logic [1:0]                 arr_sync;
    logic                       ack_s;
    logic                       done_s;

    opb_sync2 #(
        .WIDTH    (2)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in ({arr_burn_done_in, arr_burn_ack_in}),
        .sync_out (arr_sync)
    );

    assign ack_s  = arr_sync[0];
    assign done_s = arr_sync[1];

    // AXI write address and data capture
    assign axi_awready_out = !aw_held && !axi_bvalid_out;
    assign axi_wready_out  = !w_held && !axi_bvalid_out;
    assign wr_fire         = aw_held && w_held && !axi_bvalid_out;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            aw_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
        end else if (axi_awvalid_in && axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= axi_awaddr_in;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (axi_wvalid_in && axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= axi_wdata_in;
            w_strb <= axi_wstrb_in;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            axi_bvalid_out <= 1'b0;
            axi_bresp_out  <= opb_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            axi_bvalid_out <= 1'b1;
            axi_bresp_out  <= known_reg(aw_addr) ? opb_pkg::RESP_OKAY : opb_pkg::RESP_SLVERR;
        end else if (axi_bready_in) begin
            axi_bvalid_out <= 1'b0;
        end
    end

    // Write decode
    assign burn_mode_active = (op_mode_select_in == opb_pkg::MODE_BURN) && mode_ready_flag;
    assign wr_addr_reg      = wr_fire && reg_hit(aw_addr, opb_pkg::OFS_BURN_ADDR) && !buf_full;
    assign wr_data_reg      = wr_fire && reg_hit(aw_addr, opb_pkg::OFS_BURN_DATA) && !buf_full;
    assign next_addr_word   = merge_strb({20'h0_0000, burn_word_address}, w_data, w_strb);
    assign addr_valid       = next_addr_word[11:0] <= ADDR_LIMIT;
    assign burn_start       = wr_addr_reg && burn_mode_active && addr_valid;
    assign addr_err         = wr_addr_reg && burn_mode_active && !addr_valid;
    assign irq_clear        = (wr_fire && reg_hit(aw_addr, opb_pkg::OFS_IRQ_CLEAR)) ?
                              w_data[opb_pkg::IRQ_W-1:0] & {opb_pkg::IRQ_W{w_strb[0]}} :
                              {opb_pkg::IRQ_W{1'b0}};

    // Burn request buffer, address half
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            burn_word_address <= opb_pkg::BURN_ADDR_RST;
        end else if (wr_addr_reg) begin
            burn_word_address <= next_addr_word[11:0];
        end
    end

    // Burn request buffer, data half
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            burn_word_value <= opb_pkg::BURN_DATA_RST;
        end else if (wr_data_reg) begin
            burn_word_value <= merge_strb(burn_word_value, w_data, w_strb);
        end
    end

    // Buffer occupancy
    assign burn_taken = (state == opb_pkg::OPB_ST_REQ) && ack_s;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            buf_full <= !opb_pkg::STAT_EMPTY_RST;
        end else if (burn_start) begin
            buf_full <= 1'b1;
        end else if (burn_taken) begin
            buf_full <= 1'b0;
        end
    end

    // Burn sequencer toward the array
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= opb_pkg::OPB_ST_IDLE;
        end else begin
            case (state)
                opb_pkg::OPB_ST_IDLE: begin
                    if (buf_full) begin
                        state <= opb_pkg::OPB_ST_REQ;
                    end
                end
                opb_pkg::OPB_ST_REQ: begin
                    if (ack_s) begin
                        state <= opb_pkg::OPB_ST_BURN;
                    end
                end
                opb_pkg::OPB_ST_BURN: begin
                    if (done_s) begin
                        state <= opb_pkg::OPB_ST_CLOSE;
                    end
                end
                opb_pkg::OPB_ST_CLOSE: begin
                    if (!ack_s && !done_s) begin
                        state <= opb_pkg::OPB_ST_IDLE;
                    end
                end
                default: begin
                    state <= opb_pkg::OPB_ST_IDLE;
                end
            endcase
        end
    end

    assign burn_finished  = (state == opb_pkg::OPB_ST_BURN) && done_s;
    assign burn_idle_flag = (state == opb_pkg::OPB_ST_IDLE) && !buf_full;

    // Array port registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            arr_burn_req_out          <= 1'b0;
            arr_burn_word_address_out <= opb_pkg::BURN_ADDR_RST;
            arr_burn_word_value_out   <= opb_pkg::BURN_DATA_RST;
        end else if (state == opb_pkg::OPB_ST_IDLE && buf_full) begin
            arr_burn_req_out          <= 1'b1;
            arr_burn_word_address_out <= burn_word_address;
            arr_burn_word_value_out   <= burn_word_value;
        end else if (burn_taken) begin
            arr_burn_req_out          <= 1'b0;
        end
    end

    // Mode transition tracking
    assign mode_changed = (op_mode_select_in != prev_mode);
    assign mode_done    = !mode_ready_flag && !mode_changed && (settle_cnt == SETTLE_LAST);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prev_mode <= opb_pkg::MODE_DSTBY;
        end else begin
            prev_mode <= op_mode_select_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            settle_cnt <= 8'h00;
        end else if (mode_changed || mode_ready_flag) begin
            settle_cnt <= 8'h00;
        end else begin
            settle_cnt <= settle_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mode_ready_flag <= opb_pkg::STAT_MRDY_RST;
        end else if (mode_changed) begin
            mode_ready_flag <= 1'b0;
        end else if (mode_done) begin
            mode_ready_flag <= 1'b1;
        end
    end

    assign mode_ready_flag_out = mode_ready_flag;

    // Interrupt status, enable and output
    assign irq_events = {burn_taken, addr_err, mode_done, burn_finished};

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_status <= opb_pkg::IRQ_RST;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_enable <= opb_pkg::IRQ_RST;
        end else if (wr_fire && reg_hit(aw_addr, opb_pkg::OFS_IRQ_ENABLE) && w_strb[0]) begin
            irq_enable <= w_data[opb_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(((irq_status & ~irq_clear) | irq_events) & irq_enable);
        end
    end

    // Status word
    always_comb begin
        status_word                         = 32'h0000_0000;
        status_word[opb_pkg::STAT_IDLE_BIT]  = burn_idle_flag;
        status_word[opb_pkg::STAT_EMPTY_BIT] = !buf_full;
        status_word[opb_pkg::STAT_MRDY_BIT]  = mode_ready_flag;
    end

    // AXI read channel
    assign axi_arready_out = !axi_rvalid_out;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            axi_rvalid_out <= 1'b0;
            axi_rdata_out  <= 32'h0000_0000;
            axi_rresp_out  <= opb_pkg::RESP_OKAY;
        end else if (axi_arvalid_in && axi_arready_out) begin
            axi_rvalid_out <= 1'b1;
            axi_rresp_out  <= known_reg(axi_araddr_in) ? opb_pkg::RESP_OKAY
                                                       : opb_pkg::RESP_SLVERR;
            if (reg_hit(axi_araddr_in, opb_pkg::OFS_STATUS)) begin
                axi_rdata_out <= status_word;
            end else if (reg_hit(axi_araddr_in, opb_pkg::OFS_BURN_ADDR)) begin
                axi_rdata_out <= {20'h0_0000, burn_word_address};
            end else if (reg_hit(axi_araddr_in, opb_pkg::OFS_BURN_DATA)) begin
                axi_rdata_out <= burn_word_value;
            end else if (reg_hit(axi_araddr_in, opb_pkg::OFS_IRQ_STATUS)) begin
                axi_rdata_out <= {28'h000_0000, irq_status};
            end else if (reg_hit(axi_araddr_in, opb_pkg::OFS_IRQ_ENABLE)) begin
                axi_rdata_out <= {28'h000_0000, irq_enable};
            end else begin
                axi_rdata_out <= 32'h0000_0000;
            end
        end else if (axi_rready_in) begin
            axi_rvalid_out <= 1'b0;
        end
    end

endmodule

// ### test/opb_monitor.sv
// Assertion checker for the burn buffer and status block
`timescale 1ns/10ps
module opb_monitor #(
    parameter int unsigned SETTLE_CYCLES = 3,
    parameter int unsigned ADDR_MAX      = 3071
) (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    // Mode and array port
    input wire logic [2:0]  op_mode_select_in,
    input wire logic        mode_ready_flag_out,
    input wire logic        arr_burn_req_out,
    input wire logic [11:0] arr_burn_word_address_out,
    input wire logic [31:0] arr_burn_word_value_out,
    input wire logic        arr_burn_ack_in
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic [2:0] prev_mode;
    logic [5:0] quiet_cnt;
    always_ff @(posedge clk_in) begin
        prev_mode <= op_mode_select_in;
        if (!rst_n_in || op_mode_select_in != prev_mode) begin
            quiet_cnt <= 6'h00;
        end else if (quiet_cnt != 6'h3f) begin
            quiet_cnt <= quiet_cnt + 6'h01;
        end
    end
    property p_mode_drop;
        $changed(op_mode_select_in) |=> (!mode_ready_flag_out) [*4];
    endproperty
    a_mode_drop: assert property (p_mode_drop) else $error("ready not low");
    property p_mode_done;
        (quiet_cnt > SETTLE_CYCLES + 2) |-> mode_ready_flag_out;
    endproperty
    a_mode_done: assert property (p_mode_done) else $error("mode ready late");
    property p_req_mode;
        $rose(arr_burn_req_out) |-> $past(op_mode_select_in) == opb_pkg::MODE_BURN;
    endproperty
    a_req_mode: assert property (p_req_mode) else $error("burn off mode");
    property p_req_addr;
        arr_burn_req_out |-> arr_burn_word_address_out <= ADDR_MAX;
    endproperty
    a_req_addr: assert property (p_req_addr) else $error("burn address too high");
    property p_req_hold;
        arr_burn_req_out && !arr_burn_ack_in |=> arr_burn_req_out;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_req_payload;
        arr_burn_req_out && $past(arr_burn_req_out) |->
            $stable(arr_burn_word_address_out) && $stable(arr_burn_word_value_out);
    endproperty
    a_req_payload: assert property (p_req_payload) else $error("payload moved");
    property p_req_release;
        $rose(arr_burn_ack_in) |-> ##[1:5] !arr_burn_req_out;
    endproperty
    a_req_release: assert property (p_req_release) else $error("request kept");
    property p_req_fall;
        $fell(arr_burn_req_out) |-> $past(arr_burn_ack_in, 2);
    endproperty
    a_req_fall: assert property (p_req_fall) else $error("request fell");
    c_burn: cover property ($rose(arr_burn_req_out));
    c_mode: cover property ($fell(mode_ready_flag_out));
    c_ready: cover property (op_mode_select_in == opb_pkg::MODE_BURN && mode_ready_flag_out);
endmodule
bind opb_top opb_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES), .ADDR_MAX(ADDR_MAX)) i_monitor (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .op_mode_select_in(op_mode_select_in),
    .mode_ready_flag_out(mode_ready_flag_out), .arr_burn_req_out(arr_burn_req_out),
    .arr_burn_word_address_out(arr_burn_word_address_out),
    .arr_burn_word_value_out(arr_burn_word_value_out), .arr_burn_ack_in(arr_burn_ack_in));

// ### test/opb_array_model.sv
// Behavioural model of the memory array burn port
`timescale 1ns/10ps
module opb_array_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Burn handshake
    input wire logic slow_in,
    input wire logic req_in,
    output logic     ack_out,
    output logic     done_out
);
    int step;
    int wait_cnt;
    always @(posedge clk_in) begin
        wait_cnt <= wait_cnt + 1;
        if (!rst_n_in) begin
            step <= 0;
            ack_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            case (step)
                0: if (req_in) begin
                    step <= 1;
                    wait_cnt <= 0;
                end
                1: if (wait_cnt >= (slow_in ? 40 : 4)) begin
                    ack_out <= 1'b1;
                    step <= 2;
                end
                2: if (!req_in) begin
                    ack_out <= 1'b0;
                    step <= 3;
                    wait_cnt <= 0;
                end
                3: if (wait_cnt >= (slow_in ? 30 : 3)) begin
                    done_out <= 1'b1;
                    step <= 4;
                    wait_cnt <= 0;
                end
                default: if (wait_cnt >= 6) begin
                    done_out <= 1'b0;
                    step <= 0;
                end
            endcase
        end
    end
endmodule

// ### test/tb_otp_program_buffer_status.sv
// Self-checking bench for the burn buffer and status block
`timescale 1ns/10ps
module tb_otp_program_buffer_status;
    localparam int unsigned SETTLE = 12;
    localparam logic [31:0] A_ST = opb_pkg::OFS_STATUS, A_BA = opb_pkg::OFS_BURN_ADDR;
    localparam logic [31:0] A_BD = opb_pkg::OFS_BURN_DATA, A_IS = opb_pkg::OFS_IRQ_STATUS;
    localparam logic [31:0] A_IC = opb_pkg::OFS_IRQ_CLEAR, A_IE = opb_pkg::OFS_IRQ_ENABLE;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, slow = 1'b0, req_d = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        bready = 1'b1, rready = 1'b1;
    logic [2:0]  mode = 3'h0;
    logic        aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, mrdy, req, ack, done, irq;
    logic [1:0]  bresp, rresp, rsp;
    logic [11:0] badr;
    logic [31:0] rdo, bval, rdata;
    logic [31:0] seed = 32'h0001_3c35;
    logic [43:0] exp_q[$];
    int          errors = 0, checks_done = 0, cyc = 0;
    opb_top #(.SETTLE_CYCLES(SETTLE)) i_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .axi_awaddr_in(awaddr), .axi_awprot_in(3'h0), .axi_awvalid_in(awvalid),
        .axi_awready_out(aw_rdy), .axi_wdata_in(wdata), .axi_wstrb_in(4'hf),
        .axi_wvalid_in(wvalid), .axi_wready_out(w_rdy), .axi_bresp_out(bresp),
        .axi_bvalid_out(bvalid), .axi_bready_in(bready), .axi_araddr_in(araddr),
        .axi_arprot_in(3'h0), .axi_arvalid_in(arvalid), .axi_arready_out(ar_rdy),
        .axi_rdata_out(rdo), .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
        .axi_rready_in(rready), .op_mode_select_in(mode), .mode_ready_flag_out(mrdy),
        .arr_burn_req_out(req), .arr_burn_word_address_out(badr),
        .arr_burn_word_value_out(bval), .arr_burn_ack_in(ack),
        .arr_burn_done_in(done), .irq_out(irq));
    opb_array_model i_array (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
        .req_in(req), .ack_out(ack), .done_out(done));
    always #12.5 clk_in = ~clk_in;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task results();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!tb) begin
            #1;
            ta = awvalid && aw_rdy;
            tw = wvalid && w_rdy;
            tb = bvalid;
            @(posedge clk_in);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask
    task rd(input logic [31:0] a);
        logic ta, tr;
        tr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!tr) begin
            #1;
            ta = arvalid && ar_rdy;
            tr = rvalid;
            rdata = rdo;
            rsp = rresp;
            @(posedge clk_in);
            if (ta) arvalid <= 1'b0;
        end
    endtask
    task waitrdy();
        int n;
        n = 0;
        while (mrdy !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        @(posedge clk_in);
        rd(A_ST);
        chk(rdata, 32'h7);
    endtask
    task setmode(input logic [2:0] v);
        mode <= v;
        repeat (2) @(posedge clk_in);
        #1;
        chk(32'(mrdy), 32'h0);
        waitrdy();
    endtask
    task burn(input logic [11:0] a, input logic [31:0] d);
        logic go;
        int n;
        go = mode == opb_pkg::MODE_BURN && a <= 12'hbff;
        n = 0;
        wr(A_BD, d);
        if (go) exp_q.push_back({a, d});
        wr(A_BA, 32'(a));
        rd(A_ST);
        chk(rdata, {29'h0, 1'b1, !go, !go});
        if (go && slow) begin
            wr(A_BD, ~d);
            rd(A_BD);
            chk(rdata, d);
        end
        do begin
            rd(A_ST);
            n++;
        end while (rdata !== 32'h7 && n < 300);
        chk(rdata, 32'h7);
        chk(32'(exp_q.size()), 32'h0);
        rd(A_BA);
        chk(rdata, 32'(a));
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        req_d <= req;
        if (cyc == 20000) begin
            errors++;
            results();
        end
        if (rst_n_in && req === 1'b1 && req_d === 1'b0) begin
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else begin
                chk(32'(badr), 32'(exp_q[0][43:32]));
                chk(bval, exp_q[0][31:0]);
                exp_q.delete(0);
            end
        end
    end
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        rd(A_ST);
        chk(rdata, 32'h7);
        rd(A_BD);
        chk(rdata, opb_pkg::BURN_DATA_RST);
        rd(32'h07f4_0030);
        chk(32'(rsp), 32'(opb_pkg::RESP_SLVERR));
        wr(32'h07f4_0030, '0);
        chk(32'(bresp), 32'(opb_pkg::RESP_SLVERR));
        $display("test reset done");
        slow <= 1'b1;
        for (int m = 1; m < 8; m++) begin
            setmode(3'(m % 7));
            burn(12'(rnd() % 32'd3072), rnd());
        end
        $display("test modes done");
        mode <= opb_pkg::MODE_BURN;
        @(posedge clk_in);
        wr(A_BD, rnd());
        wr(A_BA, 32'h10);
        rd(A_ST);
        chk(32'(rdata[1:0]), 32'h3);
        waitrdy();
        $display("test transition done");
        slow <= 1'b0;
        wr(A_IC, 32'hf);
        wr(A_IE, 32'h1);
        burn(12'hbff, rnd());
        chk(32'(irq), 32'h1);
        rd(A_IS);
        chk(rdata, 32'h9);
        wr(A_IC, 32'h1);
        rd(A_IS);
        chk(rdata, 32'h8);
        chk(32'(irq), 32'h0);
        wr(A_IE, 32'h8);
        rd(A_IE);
        chk(32'(irq), 32'h1);
        wr(A_IE, 32'h0);
        burn(12'hc00, rnd());
        rd(A_IS);
        chk(rdata, 32'hc);
        chk(32'(irq), 32'h0);
        $display("test irq done");
        results();
    end
endmodule
